// ==== hdl/tap_pkg.sv ====
// Shared constants, types and state codes for the boundary-scan test access port.
package tap_pkg;

  localparam int IR_LEN = 3;
  localparam int ID_LEN = 32;
  localparam int USER_LEN = 8;

  // Instruction codes; all ones must stay the bypass code.
  localparam logic [IR_LEN-1:0] INSTR_IDCODE = 3'h1;
  localparam logic [IR_LEN-1:0] INSTR_USER = 3'h2;
  localparam logic [IR_LEN-1:0] INSTR_BYPASS = 3'h7;

  // Value loaded into the instruction shifter in the capture state.
  localparam logic [IR_LEN-1:0] IR_CAPTURE_VALUE = 3'h1;

  // Identification word; the value is arbitrary, only bit 0 must be one.
  localparam logic [ID_LEN-1:0] ID_CODE_DEFAULT = 32'h0A5C_3001;

  localparam logic [USER_LEN-1:0] USER_RESET_VALUE = 8'h00;

  typedef enum logic [3:0] {
    TEST_LOGIC_RESET,
    RUN_TEST_IDLE,
    SELECT_DR,
    CAPTURE_DR,
    SHIFT_DR,
    EXIT1_DR,
    PAUSE_DR,
    EXIT2_DR,
    UPDATE_DR,
    SELECT_IR,
    CAPTURE_IR,
    SHIFT_IR,
    EXIT1_IR,
    PAUSE_IR,
    EXIT2_IR,
    UPDATE_IR
  } tap_state_e;

  // Word handed from the test port to the system side.
  typedef struct packed {
    logic valid;
    logic [USER_LEN-1:0] data;
  } user_word_s;

  // Serial output pin as its two driven signals.
  typedef struct packed {
    logic data;
    logic oe_n;
  } serial_pin_s;

endpackage : tap_pkg

// ==== hdl/tap_port.sv ====
// Boundary-scan test access port with a system-clock side for the user register.
//
// Behaviour
// - Test reset low resets the port controller at once, without a test clock edge.
// - Rising test reset leaves the identification instruction selected for scanning.
// - While test reset is held low the device runs in normal functional mode.
// - Mode select is sampled on rising test clock and steers the controller state.
// - Serial input bits are captured on each rising test clock edge in the two shift states.
// - Serial output changes only on falling test clock edges or at once when test reset goes low.
`timescale 1ns/1ps

module tap_port
  import tap_pkg::*;
#(
  parameter logic [ID_LEN-1:0] ID_CODE = ID_CODE_DEFAULT
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic tap_clock,
  input wire logic tap_reset_in_n,
  input wire logic tap_mode_select,
  input wire logic tap_serial_in,
  output serial_pin_s tap_serial_out,
  output logic test_mode,
  output user_word_s user_out
);

  // Test clock domain state.
  tap_state_e state_ff;
  tap_state_e nxt_state;
  logic [IR_LEN-1:0] ir_shift_ff;
  logic [IR_LEN-1:0] nxt_ir_shift;
  logic [IR_LEN-1:0] ir_ff;
  logic [IR_LEN-1:0] nxt_ir;
  logic [ID_LEN-1:0] id_shift_ff;
  logic [ID_LEN-1:0] nxt_id_shift;
  logic bypass_ff;
  logic nxt_bypass;
  logic [USER_LEN-1:0] user_shift_ff;
  logic [USER_LEN-1:0] nxt_user_shift;
  logic [USER_LEN-1:0] user_hold_ff;
  logic [USER_LEN-1:0] nxt_user_hold;
  logic update_tgl_ff;
  logic nxt_update_tgl;

  // Falling-edge output stage.
  logic tdo_ff;
  logic nxt_tdo;
  logic tdo_oe_n_ff;
  logic nxt_tdo_oe_n;

  // System clock domain state.
  logic mode_meta_ff;
  logic mode_sync_ff;
  logic tgl_meta_ff;
  logic tgl_sync_ff;
  logic tgl_seen_ff;
  logic nxt_mode_meta;
  logic nxt_mode_sync;
  logic nxt_tgl_meta;
  logic nxt_tgl_sync;
  logic nxt_tgl_seen;
  user_word_s user_ff;
  user_word_s nxt_user;

  // Data register that the current instruction places between the serial pins.
  typedef enum logic [1:0] {
    SEL_ID,
    SEL_USER,
    SEL_BYPASS
  } dr_sel_e;

  dr_sel_e dr_sel;

  // Unknown codes fall back to bypass so the chain length stays defined.
  function automatic dr_sel_e dr_select(input logic [IR_LEN-1:0] code);
    dr_sel_e res;
    res = SEL_BYPASS;
    if (code == INSTR_IDCODE)
    begin
      res = SEL_ID;
    end
    else if (code == INSTR_USER)
    begin
      res = SEL_USER;
    end
    return res;
  endfunction : dr_select

  function automatic tap_state_e step(input tap_state_e cur, input logic tms);
    tap_state_e res;
    res = cur;
    unique case (cur)
      TEST_LOGIC_RESET: res = tms ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
      RUN_TEST_IDLE: res = tms ? SELECT_DR : RUN_TEST_IDLE;
      SELECT_DR: res = tms ? SELECT_IR : CAPTURE_DR;
      CAPTURE_DR: res = tms ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR: res = tms ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR: res = tms ? UPDATE_DR : PAUSE_DR;
      PAUSE_DR: res = tms ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR: res = tms ? UPDATE_DR : SHIFT_DR;
      UPDATE_DR: res = tms ? SELECT_DR : RUN_TEST_IDLE;
      SELECT_IR: res = tms ? TEST_LOGIC_RESET : CAPTURE_IR;
      CAPTURE_IR: res = tms ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR: res = tms ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR: res = tms ? UPDATE_IR : PAUSE_IR;
      PAUSE_IR: res = tms ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR: res = tms ? UPDATE_IR : SHIFT_IR;
      UPDATE_IR: res = tms ? SELECT_DR : RUN_TEST_IDLE;
    endcase
    return res;
  endfunction : step

  assign dr_sel = dr_select(ir_ff);

  // The controller advances on the rising test clock edge from the sampled mode select.
  always_comb
  begin
    nxt_state = step(state_ff, tap_mode_select);
  end

  // Test reset clears the controller without any test clock edge.
  always_ff @(posedge tap_clock or negedge tap_reset_in_n)
  begin
    if (!tap_reset_in_n)
    begin
      state_ff <= TEST_LOGIC_RESET;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Instruction and data registers act on the state held before each rising edge.
  always_comb
  begin
    nxt_ir_shift = ir_shift_ff;
    nxt_ir = ir_ff;
    nxt_id_shift = id_shift_ff;
    nxt_bypass = bypass_ff;
    nxt_user_shift = user_shift_ff;
    nxt_user_hold = user_hold_ff;
    nxt_update_tgl = update_tgl_ff;
    unique case (state_ff)
      TEST_LOGIC_RESET:
      begin
        nxt_ir = INSTR_IDCODE;
      end
      CAPTURE_IR:
      begin
        nxt_ir_shift = IR_CAPTURE_VALUE;
      end
      SHIFT_IR:
      begin
        nxt_ir_shift = {tap_serial_in, ir_shift_ff[IR_LEN-1:1]};
      end
      UPDATE_IR:
      begin
        nxt_ir = ir_shift_ff;
      end
      CAPTURE_DR:
      begin
        nxt_id_shift = ID_CODE;
        nxt_bypass = 1'b0;
        nxt_user_shift = user_hold_ff;
      end
      SHIFT_DR:
      begin
        unique case (dr_sel)
          SEL_ID: nxt_id_shift = {tap_serial_in, id_shift_ff[ID_LEN-1:1]};
          SEL_USER: nxt_user_shift = {tap_serial_in, user_shift_ff[USER_LEN-1:1]};
          default: nxt_bypass = tap_serial_in;
        endcase
      end
      UPDATE_DR:
      begin
        if (dr_sel == SEL_USER)
        begin
          nxt_user_hold = user_shift_ff;
          nxt_update_tgl = ~update_tgl_ff;
        end
      end
      default:
      begin
      end
    endcase
  end

  // Test reset also puts back the identification instruction, ready for the first scan.
  always_ff @(posedge tap_clock or negedge tap_reset_in_n)
  begin
    if (!tap_reset_in_n)
    begin
      ir_ff <= INSTR_IDCODE;
      ir_shift_ff <= IR_CAPTURE_VALUE;
      id_shift_ff <= ID_CODE;
      bypass_ff <= 1'b0;
      user_shift_ff <= USER_RESET_VALUE;
      user_hold_ff <= USER_RESET_VALUE;
      update_tgl_ff <= 1'b0;
    end
    else
    begin
      ir_ff <= nxt_ir;
      ir_shift_ff <= nxt_ir_shift;
      id_shift_ff <= nxt_id_shift;
      bypass_ff <= nxt_bypass;
      user_shift_ff <= nxt_user_shift;
      user_hold_ff <= nxt_user_hold;
      update_tgl_ff <= nxt_update_tgl;
    end
  end

  // Output stage; driving on the falling edge gives the far end half a period of hold.
  always_comb
  begin
    nxt_tdo = 1'b0;
    nxt_tdo_oe_n = 1'b1;
    if (state_ff == SHIFT_IR)
    begin
      nxt_tdo = ir_shift_ff[0];
      nxt_tdo_oe_n = 1'b0;
    end
    else if (state_ff == SHIFT_DR)
    begin
      nxt_tdo_oe_n = 1'b0;
      unique case (dr_sel)
        SEL_ID: nxt_tdo = id_shift_ff[0];
        SEL_USER: nxt_tdo = user_shift_ff[0];
        default: nxt_tdo = bypass_ff;
      endcase
    end
  end

  always_ff @(negedge tap_clock or negedge tap_reset_in_n)
  begin
    if (!tap_reset_in_n)
    begin
      tdo_ff <= 1'b0;
      tdo_oe_n_ff <= 1'b1;
    end
    else
    begin
      tdo_ff <= nxt_tdo;
      tdo_oe_n_ff <= nxt_tdo_oe_n;
    end
  end

  assign tap_serial_out = serial_pin_s'{data: tdo_ff, oe_n: tdo_oe_n_ff};

  // System side: the test reset level passes two flip-flops before anything reads it.
  always_comb
  begin
    nxt_mode_meta = tap_reset_in_n;
    nxt_mode_sync = mode_meta_ff;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mode_meta_ff <= 1'b0;
      mode_sync_ff <= 1'b0;
    end
    else
    begin
      mode_meta_ff <= nxt_mode_meta;
      mode_sync_ff <= nxt_mode_sync;
    end
  end

  // The update toggle passes two flip-flops; the held word is read only after it settled.
  always_comb
  begin
    nxt_tgl_meta = update_tgl_ff;
    nxt_tgl_sync = tgl_meta_ff;
    nxt_tgl_seen = tgl_sync_ff;
    nxt_user.valid = 1'b0;
    nxt_user.data = user_ff.data;
    // The held word changed with the toggle and then stays put for many test clocks.
    if (tgl_sync_ff != tgl_seen_ff)
    begin
      nxt_user.valid = 1'b1;
      nxt_user.data = user_hold_ff;
    end
    // Functional mode is forced while the port is held in test reset.
    if (!mode_sync_ff)
    begin
      nxt_user.valid = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tgl_meta_ff <= 1'b0;
      tgl_sync_ff <= 1'b0;
      tgl_seen_ff <= 1'b0;
      user_ff <= '0;
    end
    else
    begin
      tgl_meta_ff <= nxt_tgl_meta;
      tgl_sync_ff <= nxt_tgl_sync;
      tgl_seen_ff <= nxt_tgl_seen;
      user_ff <= nxt_user;
    end
  end

  // Low test reset means normal operation; high means the port owns the device.
  assign test_mode = mode_sync_ff;
  assign user_out = user_ff;

endmodule : tap_port

// ==== verification/boundary_scan_tap_pins_test.sv ====
// Self-checking bench for the test access port.
`timescale 1ns/1ps
module boundary_scan_tap_pins_test;
  import tap_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic tap_clock, tap_reset_in_n, tap_mode_select, tap_serial_in, test_mode, q;
  serial_pin_s tap_serial_out;
  user_word_s user_out;
  int n_fail = 0;
  int compares = 0;
  int seen_ff = 0;
  logic [7:0] word_ff = 8'h00;
  logic [31:0] got;
  always #5 clk = ~clk;
  always @(posedge clk)
    if (user_out.valid === 1'b1)
    begin
      seen_ff <= seen_ff + 1;
      word_ff <= user_out.data;
    end
  tap_port u_dut (.clk(clk), .reset(reset), .tap_clock(tap_clock), .tap_reset_in_n(tap_reset_in_n),
    .tap_mode_select(tap_mode_select), .tap_serial_in(tap_serial_in), .tap_serial_out(tap_serial_out),
    .test_mode(test_mode), .user_out(user_out));
  tap_ctrl_model u_ctrl (.tap_clock(tap_clock), .tap_reset_in_n(tap_reset_in_n),
    .tap_mode_select(tap_mode_select), .tap_serial_in(tap_serial_in), .tap_serial_out(tap_serial_out));
  task automatic finish_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check
  task automatic wait_word(input int n, input logic [7:0] e);
    int i;
    for (i = 0; i < 40 && seen_ff < n; i++)
      @(negedge clk);
    if (seen_ff < n)
    begin
      n_fail++;
      finish_test();
    end
    check(word_ff, e);
  endtask : wait_word
  task automatic t_idcode;
    u_ctrl.set_reset(1'b1);
    repeat (6) @(negedge clk);
    check(test_mode, 1'b1);
    u_ctrl.scan(1'b0, 32'h0, ID_LEN, got);
    check(got, ID_CODE_DEFAULT);
  endtask : t_idcode
  task automatic t_user;
    u_ctrl.scan(1'b1, INSTR_USER, IR_LEN, got);
    check(got, IR_CAPTURE_VALUE);
    u_ctrl.scan(1'b0, 32'hA5, USER_LEN, got);
    check(got, USER_RESET_VALUE);
    wait_word(1, 8'hA5);
    u_ctrl.scan(1'b0, 32'h3C, USER_LEN, got);
    check(got, 32'hA5);
    wait_word(2, 8'h3C);
  endtask : t_user
  task automatic t_bypass;
    u_ctrl.scan(1'b1, INSTR_BYPASS, IR_LEN, got);
    check(got, IR_CAPTURE_VALUE);
    u_ctrl.scan(1'b0, 32'h0B, 5, got);
    check(got, 32'h16);
    // An unassigned code must also select the one-bit bypass path.
    u_ctrl.scan(1'b1, 32'h5, IR_LEN, got);
    check(got, IR_CAPTURE_VALUE);
    u_ctrl.scan(1'b0, 32'h13, 5, got);
    check(got, 32'h06);
  endtask : t_bypass
  task automatic t_reset;
    repeat (5) u_ctrl.step(1'b1, 1'b0, q);
    u_ctrl.scan(1'b0, 32'h0, ID_LEN, got);
    check(got, ID_CODE_DEFAULT);
    u_ctrl.step(1'b1, 1'b0, q);
    u_ctrl.step(1'b0, 1'b0, q);
    u_ctrl.step(1'b0, 1'b0, q);
    check(tap_serial_out.oe_n, 1'b0);
    u_ctrl.set_reset(1'b0);
    repeat (6) @(negedge clk);
    check(tap_serial_out, 32'h1);
    check(test_mode, 1'b0);
    u_ctrl.set_reset(1'b1);
    u_ctrl.scan(1'b0, 32'h0, ID_LEN, got);
    check(got, ID_CODE_DEFAULT);
  endtask : t_reset
  initial
  begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    t_idcode();
    t_user();
    t_bypass();
    t_reset();
    finish_test();
  end
endmodule : boundary_scan_tap_pins_test
bind tap_port tap_port_monitor u_mon (.clk(clk), .reset(reset), .tap_clock(tap_clock),
  .tap_reset_in_n(tap_reset_in_n), .tap_mode_select(tap_mode_select), .tap_serial_in(tap_serial_in),
  .tap_serial_out(tap_serial_out), .test_mode(test_mode), .user_out(user_out));

// ==== verification/tap_ctrl_model.sv ====
// Behavioural test controller on the five-wire link (clock, reset, mode select, serial in, serial out).
`timescale 1ns/1ps
module tap_ctrl_model
  import tap_pkg::*;
(
  output logic tap_clock,
  output logic tap_reset_in_n,
  output logic tap_mode_select,
  output logic tap_serial_in,
  input wire serial_pin_s tap_serial_out
);
  logic last_ff = 1'b0;
  logic line;
  // The pin has no pull, so a released pin shows a changing level, never a stale bit.
  assign line = tap_serial_out.oe_n ? ~last_ff : tap_serial_out.data;
  always @(posedge tap_clock)
    last_ff <= line;
  initial
  begin
    tap_clock = 1'b0;
    tap_reset_in_n = 1'b1;
    tap_mode_select = 1'b1;
    tap_serial_in = 1'b1;
    // A clean falling edge after time zero, so the port cannot miss its power-up reset.
    #2 tap_reset_in_n = 1'b0;
  end
  // The clock stands low between steps.
  task automatic step(input logic m, input logic d, output logic q);
    tap_mode_select = m;
    tap_serial_in = d;
    #23 tap_clock = 1'b1;
    q = line;
    #40 tap_clock = 1'b0;
    #17;
  endtask : step
  task automatic set_reset(input logic v);
    #20 tap_reset_in_n = v;
    #60;
  endtask : set_reset
  task automatic scan(input logic ir, input logic [31:0] din, input int n, output logic [31:0] dout);
    logic q;
    dout = '0;
    step(1'b0, 1'b0, q);
    step(1'b1, 1'b0, q);
    if (ir)
      step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : scan
endmodule : tap_ctrl_model

// ==== verification/tap_port_monitor.sv ====
// Concurrent checks on the test port pins.
`timescale 1ns/1ps
module tap_port_monitor
  import tap_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic tap_clock,
  input wire logic tap_reset_in_n,
  input wire logic tap_mode_select,
  input wire logic tap_serial_in,
  input wire serial_pin_s tap_serial_out,
  input wire logic test_mode,
  input wire user_word_s user_out
);
  out_edge_a: assert property (@(posedge clk) disable iff (reset)
    tap_clock && $past(tap_clock) && tap_reset_in_n && $past(tap_reset_in_n) |-> $stable(tap_serial_out))
    else $error("out moved");
  async_rst_a: assert property (@(posedge clk) disable iff (reset)
    !tap_reset_in_n && !$past(tap_reset_in_n) |-> tap_serial_out == 2'h1) else $error("no reset");
  mode_off_a: assert property (@(posedge clk) disable iff (reset)
    $fell(tap_reset_in_n) |-> ##[1:4] !test_mode) else $error("mode on");
  mode_on_a: assert property (@(posedge clk) disable iff (reset)
    $rose(tap_reset_in_n) |-> ##[1:4] test_mode) else $error("mode off");
  no_pulse_a: assert property (@(posedge clk) disable iff (reset)
    !test_mode && !$past(test_mode) |-> !user_out.valid) else $error("pulse");
  pulse_len_a: assert property (@(posedge clk) disable iff (reset)
    user_out.valid |=> !user_out.valid) else $error("long");
  data_hold_a: assert property (@(posedge clk) disable iff (reset)
    $changed(user_out.data) |-> user_out.valid) else $error("data");
  shift_exit_a: assert property (@(posedge tap_clock) disable iff (!tap_reset_in_n)
    !tap_serial_out.oe_n && tap_mode_select |=> tap_serial_out.oe_n) else $error("exit");
  cover property (@(posedge clk) user_out.valid);
  cover property (@(posedge clk) $fell(tap_reset_in_n));
  cover property (@(posedge clk) $rose(test_mode));
  cover property (@(posedge tap_clock) !tap_serial_out.oe_n);
endmodule : tap_port_monitor
